// file: src/ouhbp_pkg.sv
// =============================================================
// Shared constants and types of the host bus port
// =============================================================
package ouhbp_pkg;

   // =============================================================
   // Address field layout
   // =============================================================
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned INDEX_LSB     = 0;
   localparam int unsigned INDEX_W       = 4;
   localparam int unsigned CHAN_LSB      = 4;
   localparam int unsigned CHAN_W        = 3;
   localparam int unsigned GLOBAL_BIT    = 7;
   localparam int unsigned NUM_CHAN      = 8;

   // =============================================================
   // Global register indexes and reset values
   // =============================================================
   localparam logic [3:0] GLB_INT_SRC_IDX = 4'h0;
   localparam logic [7:0] DATA_RST        = 8'h00;
   localparam logic [7:0] IRQ_RST         = 8'h00;
   localparam logic       SER_IDLE        = 1'b1;

   // =============================================================
   // Carriers
   // =============================================================
   typedef struct packed {
      logic       global_sel;
      logic [2:0] chan;
      logic [3:0] index;
      logic [7:0] wdata;
   } ouhbp_req_t;

   typedef struct packed {
      logic       bus_mode;
      logic       sel_n;
      logic       rd_strobe_n;
      logic       wr_strobe_n;
      logic [7:0] addr;
      logic [7:0] data;
   } ouhbp_pins_t;

   localparam ouhbp_req_t  REQ_RST  = '{global_sel: 1'b0, chan: 3'h0, index: 4'h0, wdata: 8'h00};
   localparam ouhbp_pins_t PINS_RST = '{bus_mode: 1'b1, sel_n: 1'b1, rd_strobe_n: 1'b1,
                                        wr_strobe_n: 1'b1, addr: 8'h00, data: 8'h00};

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RD_WAIT,
      ST_RD_DRIVE,
      ST_WR_ACT
   } ouhbp_state_t;

endpackage

// file: src/ouhbp_host_port.sv
`timescale 1ns/10ps
module ouhbp_host_port (
   input  wire logic                      mclk_i,
   input  wire logic                      rst_i,
   input  wire logic                      ce_i,
   input  wire logic                      bus_mode_i,
   input  wire logic [7:0]                host_addr_i,
   input  wire logic [7:0]                host_data_i,
   output logic      [7:0]                host_data_o,
   output logic                           host_data_oe_n_o,
   input  wire logic                      rd_strobe_n_i,
   input  wire logic                      wr_strobe_n_i,
   input  wire logic                      sel_n_i,
   input  wire logic                      int_n_i,
   output logic                           int_n_o,
   output logic                           int_n_oe_n_o,
   output logic                           int_line_low_o,
   output ouhbp_pkg::ouhbp_req_t          reg_req_o,
   output logic                           reg_rd_o,
   output logic                           reg_wr_o,
   input  wire logic [7:0]                reg_rdata_i,
   input  wire logic [7:0]                chan_irq_i,
   input  wire logic                      ser_in_ch0_i,
   output logic                           rx_core_o,
   input  wire logic                      ir_mode_i,
   input  wire logic                      ir_invert_i,
   input  wire logic                      tx_uart_i,
   input  wire logic                      tx_ir_i,
   output logic                           ser_out_ch0_o
);

   // =============================================================
   // Pin synchronisers
   // =============================================================
   ouhbp_pkg::ouhbp_pins_t pins_meta;
   ouhbp_pkg::ouhbp_pins_t pins_s2;
   ouhbp_pkg::ouhbp_pins_t next_pins_meta;
   logic                   rx_meta;
   logic                   rx_s2;
   logic                   int_meta;
   logic                   int_s2;

   always_comb
   begin
      next_pins_meta = '{bus_mode: bus_mode_i, sel_n: sel_n_i, rd_strobe_n: rd_strobe_n_i,
                         wr_strobe_n: wr_strobe_n_i, addr: host_addr_i, data: host_data_i};
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pins_meta <= ouhbp_pkg::PINS_RST;
         pins_s2   <= ouhbp_pkg::PINS_RST;
         rx_meta   <= ouhbp_pkg::SER_IDLE;
         rx_s2     <= ouhbp_pkg::SER_IDLE;
         int_meta  <= 1'b1;
         int_s2    <= 1'b1;
      end
      else if (ce_i)
      begin
         pins_meta <= next_pins_meta;
         pins_s2   <= pins_meta;
         rx_meta   <= ser_in_ch0_i;
         rx_s2     <= rx_meta;
         int_meta  <= int_n_i;
         int_s2    <= int_meta;
      end
   end

   // =============================================================
   // Access decode
   // =============================================================
   logic act_now;
   logic rd_now;

   always_comb
   begin
      if (pins_s2.bus_mode)
      begin
         act_now = !pins_s2.sel_n && (!pins_s2.rd_strobe_n || !pins_s2.wr_strobe_n);
         rd_now  = !pins_s2.rd_strobe_n;
      end
      else
      begin
         act_now = !pins_s2.sel_n;
         rd_now  = pins_s2.wr_strobe_n;
      end
   end

   // =============================================================
   // Bus cycle state machine
   // =============================================================
   ouhbp_pkg::ouhbp_state_t state;
   ouhbp_pkg::ouhbp_state_t next_state;
   ouhbp_pkg::ouhbp_req_t   next_req;
   logic                    next_rd;
   logic                    next_wr;
   logic [7:0]              next_data_out;
   logic                    next_oe_n;
   logic                    is_int_src;
   logic [7:0]              irq_s;

   always_comb
   begin
      next_state    = state;
      next_req      = reg_req_o;
      next_rd       = 1'b0;
      next_wr       = 1'b0;
      next_data_out = host_data_o;
      next_oe_n     = 1'b1;
      is_int_src    = reg_req_o.global_sel && (reg_req_o.index == ouhbp_pkg::GLB_INT_SRC_IDX);
      case (state)
         ouhbp_pkg::ST_IDLE:
         begin
            if (act_now)
            begin
               next_req.index      = pins_s2.addr[ouhbp_pkg::INDEX_LSB +: ouhbp_pkg::INDEX_W];
               next_req.chan       = pins_s2.addr[ouhbp_pkg::CHAN_LSB +: ouhbp_pkg::CHAN_W];
               next_req.global_sel = pins_s2.addr[ouhbp_pkg::GLOBAL_BIT];
               next_req.wdata      = pins_s2.data;
               if (rd_now)
               begin
                  next_state = ouhbp_pkg::ST_RD_WAIT;
                  next_rd    = !(pins_s2.addr[ouhbp_pkg::GLOBAL_BIT]
                                 && (pins_s2.addr[3:0] == ouhbp_pkg::GLB_INT_SRC_IDX));
               end
               else
               begin
                  next_state = ouhbp_pkg::ST_WR_ACT;
               end
            end
         end
         ouhbp_pkg::ST_RD_WAIT:
         begin
            next_data_out = is_int_src ? irq_s : reg_rdata_i;
            if (act_now)
            begin
               next_state = ouhbp_pkg::ST_RD_DRIVE;
               next_oe_n  = 1'b0;
            end
            else
            begin
               next_state = ouhbp_pkg::ST_IDLE;
            end
         end
         ouhbp_pkg::ST_RD_DRIVE:
         begin
            if (act_now)
            begin
               next_oe_n = 1'b0;
            end
            else
            begin
               next_state = ouhbp_pkg::ST_IDLE;
            end
         end
         ouhbp_pkg::ST_WR_ACT:
         begin
            if (act_now)
            begin
               next_req.wdata = pins_s2.data;
            end
            else
            begin
               next_wr    = 1'b1;
               next_state = ouhbp_pkg::ST_IDLE;
            end
         end
         default:
         begin
            next_state = ouhbp_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state            <= ouhbp_pkg::ST_IDLE;
         reg_req_o        <= ouhbp_pkg::REQ_RST;
         reg_rd_o         <= 1'b0;
         reg_wr_o         <= 1'b0;
         host_data_o      <= ouhbp_pkg::DATA_RST;
         host_data_oe_n_o <= 1'b1;
      end
      else if (ce_i)
      begin
         state            <= next_state;
         reg_req_o        <= next_req;
         reg_rd_o         <= next_rd;
         reg_wr_o         <= next_wr;
         host_data_o      <= next_data_out;
         host_data_oe_n_o <= next_oe_n;
      end
   end

   // =============================================================
   // Interrupt and serial pins
   // =============================================================
   logic       next_int_oe_n;
   logic       next_rx_core;
   logic       next_ser_out;

   always_comb
   begin
      next_int_oe_n = !(|irq_s);
      next_rx_core  = (ir_mode_i && ir_invert_i) ? !rx_s2 : rx_s2;
      next_ser_out  = ir_mode_i ? tx_ir_i : tx_uart_i;
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_s          <= ouhbp_pkg::IRQ_RST;
         int_n_o        <= 1'b0;
         int_n_oe_n_o   <= 1'b1;
         int_line_low_o <= 1'b0;
         rx_core_o      <= ouhbp_pkg::SER_IDLE;
         ser_out_ch0_o  <= ouhbp_pkg::SER_IDLE;
      end
      else if (ce_i)
      begin
         irq_s          <= chan_irq_i;
         int_n_o        <= 1'b0;
         int_n_oe_n_o   <= next_int_oe_n;
         int_line_low_o <= !int_s2;
         rx_core_o      <= next_rx_core;
         ser_out_ch0_o  <= next_ser_out;
      end
   end

   // =============================================================
   // Assertions
   // =============================================================
   addr_split_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      reg_rd_o |-> (reg_req_o.chan == $past(pins_s2.addr[6:4])) && (reg_req_o.index == $past(pins_s2.addr[3:0])))
      else $error("Address split into channel and index is wrong");

   global_route_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      $rose(state == ouhbp_pkg::ST_RD_WAIT) |-> reg_req_o.global_sel == $past(pins_s2.addr[7]))
      else $error("Global select does not follow top address bit");

   rd_start_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      (state == ouhbp_pkg::ST_IDLE && pins_s2.bus_mode && !pins_s2.sel_n && !pins_s2.rd_strobe_n)
      |=> state == ouhbp_pkg::ST_RD_WAIT)
      else $error("Read strobe did not start a read");

   read_drive_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      (state == ouhbp_pkg::ST_RD_WAIT && act_now)
      |=> !host_data_oe_n_o && (host_data_o == ($past(is_int_src) ? $past(irq_s) : $past(reg_rdata_i))))
      else $error("Read byte not driven after fetch");

   wr_commit_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      (state == ouhbp_pkg::ST_WR_ACT && !act_now) |=> reg_wr_o && (reg_req_o.wdata == $past(reg_req_o.wdata)))
      else $error("Write not committed at closing edge");

   dir_line_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      (state == ouhbp_pkg::ST_IDLE && !pins_s2.bus_mode && !pins_s2.sel_n && !pins_s2.wr_strobe_n)
      |=> state == ouhbp_pkg::ST_WR_ACT ##1 !reg_rd_o)
      else $error("Direction line low did not start a write");

   chip_sel_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      (state == ouhbp_pkg::ST_IDLE && pins_s2.bus_mode && pins_s2.sel_n) |=> state == ouhbp_pkg::ST_IDLE)
      else $error("Access started without chip select");

   strobe_sel_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      (state == ouhbp_pkg::ST_RD_DRIVE && !pins_s2.bus_mode && pins_s2.sel_n) |=> host_data_oe_n_o)
      else $error("Read not closed by select strobe");

   bus_release_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      !host_data_oe_n_o |-> state == ouhbp_pkg::ST_RD_DRIVE)
      else $error("Data bus driven outside a read");

   int_shared_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      (|chan_irq_i) |=> ##1 !int_n_oe_n_o && !int_n_o)
      else $error("Channel interrupt not driven on shared line");

   rx_idle_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      !$past(ir_mode_i) |-> rx_core_o == $past(rx_s2))
      else $error("Normal receive path altered");

   ir_invert_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      $past(ir_mode_i && ir_invert_i) |-> rx_core_o == !$past(rx_s2))
      else $error("Infrared receive not inverted");

   tx_select_a: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      !$past(rst_i) |-> ser_out_ch0_o == ($past(ir_mode_i) ? $past(tx_ir_i) : $past(tx_uart_i)))
      else $error("Transmit source not selected by mode");

   rd_cycle_c: cover property (@(posedge mclk_i) disable iff (rst_i)
      reg_rd_o ##1 !host_data_oe_n_o ##[1:50] host_data_oe_n_o);

   wr_cycle_c: cover property (@(posedge mclk_i) disable iff (rst_i)
      state == ouhbp_pkg::ST_WR_ACT ##[1:50] reg_wr_o);

   int_src_c: cover property (@(posedge mclk_i) disable iff (rst_i)
      state == ouhbp_pkg::ST_RD_WAIT && reg_req_o.global_sel && !reg_rd_o);

endmodule // ouhbp_host_port

// file: tb/ouhbp_host_model.sv
`timescale 1ns/10ps
// ====================
// Host processor model
// ====================
module ouhbp_host_model (
   input  wire logic              mclk_i,
   input  wire logic [7:0]        dev_data_i,
   input  wire logic              dev_oe_n_i,
   output ouhbp_pkg::ouhbp_pins_t pins_o
);
   ouhbp_pkg::ouhbp_pins_t drv      = ouhbp_pkg::PINS_RST;
   logic                   data_en  = 1'b0;
   logic [7:0]             last_bus = 8'h00;

   // Released bus toggles every cycle
   always_comb
   begin
      pins_o      = drv;
      pins_o.data = !dev_oe_n_i ? dev_data_i : (data_en ? drv.data : ~last_bus);
   end

   always @(posedge mclk_i) last_bus <= pins_o.data;

   task automatic set_mode(input logic m);
      @(posedge mclk_i);
      drv.bus_mode    <= m;
      drv.wr_strobe_n <= 1'b1;
      repeat (6) @(posedge mclk_i);
   endtask

   // Strobe held 8 cycles, recovery 6 cycles
   task automatic access(input logic wr, input logic cs, input logic [7:0] a, input logic [7:0] wd,
                         output logic [7:0] rd);
      @(posedge mclk_i);
      drv.addr        <= a;
      drv.data        <= wd;
      data_en         <= wr;
      drv.rd_strobe_n <= 1'b1;
      drv.wr_strobe_n <= drv.bus_mode | !wr;
      drv.sel_n       <= !(cs & drv.bus_mode);
      @(posedge mclk_i);
      if (!drv.bus_mode)
         drv.sel_n <= 1'b0;
      else if (wr)
         drv.wr_strobe_n <= 1'b0;
      else
         drv.rd_strobe_n <= 1'b0;
      repeat (8) @(posedge mclk_i);
      rd = pins_o.data;
      drv.rd_strobe_n <= 1'b1;
      drv.wr_strobe_n <= drv.bus_mode | !wr;
      if (!drv.bus_mode)
         drv.sel_n <= 1'b1;
      @(posedge mclk_i);
      drv.sel_n <= 1'b1;
      data_en   <= 1'b0;
      repeat (6) @(posedge mclk_i);
   endtask
endmodule // ouhbp_host_model

// file: tb/tb.sv
`timescale 1ns/10ps
// ====================
// Host bus port bench
// ====================
module tb;
   logic                   mclk_i    = 1'b0;
   logic                   rst_i     = 1'b1;
   logic [7:0]             chan_irq  = 8'h00;
   logic [3:0]             ser_ctl   = 4'h2;
   logic [7:0]             dev_data;
   logic [7:0]             core_data;
   logic                   oe_n;
   logic                   int_n;
   logic                   int_oe_n;
   logic                   int_low;
   logic                   reg_rd;
   logic                   reg_wr;
   logic                   rx_core;
   logic                   ser_out;
   ouhbp_pkg::ouhbp_req_t  req;
   ouhbp_pkg::ouhbp_req_t  last_rd;
   ouhbp_pkg::ouhbp_req_t  last_wr;
   ouhbp_pkg::ouhbp_pins_t pins;
   int                     failures  = 0;
   int                     tests_run = 0;
   int                     rd_cnt    = 0;
   int                     wr_cnt    = 0;
   int                     oe_cnt    = 0;
   int                     cycles    = 0;

   // Core answers with its own address pattern XOR 5a
   assign core_data = {req.global_sel, req.chan, req.index} ^ 8'h5a;

   ouhbp_host_model u_ouhbp_host_model (
      .mclk_i     (mclk_i),
      .dev_data_i (dev_data),
      .dev_oe_n_i (oe_n),
      .pins_o     (pins)
   );

   ouhbp_host_port u_ouhbp_host_port (
      .mclk_i           (mclk_i),
      .rst_i            (rst_i),
      .ce_i             (1'b1),
      .bus_mode_i       (pins.bus_mode),
      .host_addr_i      (pins.addr),
      .host_data_i      (pins.data),
      .host_data_o      (dev_data),
      .host_data_oe_n_o (oe_n),
      .rd_strobe_n_i    (pins.rd_strobe_n),
      .wr_strobe_n_i    (pins.wr_strobe_n),
      .sel_n_i          (pins.sel_n),
      .int_n_i          (int_oe_n | int_n),
      .int_n_o          (int_n),
      .int_n_oe_n_o     (int_oe_n),
      .int_line_low_o   (int_low),
      .reg_req_o        (req),
      .reg_rd_o         (reg_rd),
      .reg_wr_o         (reg_wr),
      .reg_rdata_i      (core_data),
      .chan_irq_i       (chan_irq),
      .ser_in_ch0_i     (ser_ctl[1]),
      .rx_core_o        (rx_core),
      .ir_mode_i        (ser_ctl[3]),
      .ir_invert_i      (ser_ctl[2]),
      .tx_uart_i        (ser_ctl[0]),
      .tx_ir_i          (!ser_ctl[0]),
      .ser_out_ch0_o    (ser_out)
   );

   initial forever #25 mclk_i = ~mclk_i;

   // ====================
   // Monitor and timeout
   // ====================
   always @(posedge mclk_i)
   begin
      cycles <= cycles + 1;
      oe_cnt <= oe_cnt + int'(!oe_n);
      if (reg_rd)
      begin
         rd_cnt  <= rd_cnt + 1;
         last_rd <= req;
      end
      if (reg_wr)
      begin
         wr_cnt  <= wr_cnt + 1;
         last_wr <= req;
      end
      if (cycles == 6000)
      begin
         failures = failures + 1;
         $display("ERROR t=%0t run timed out", $time);
         finish_test();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("ERROR t=%0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ====================
   // Scenarios
   // ====================
   task automatic test_serial();
      for (int i = 0; i < 16; i++)
      begin
         @(posedge mclk_i);
         ser_ctl <= 4'(i);
         repeat (5) @(posedge mclk_i);
         check(8'(rx_core), 8'(ser_ctl[1] ^ (ser_ctl[3] & ser_ctl[2])), "receive path");
         check(8'(ser_out), 8'(ser_ctl[3] ? !ser_ctl[0] : ser_ctl[0]), "transmit select");
      end
      @(posedge mclk_i);
      ser_ctl <= 4'h2;
      $display("test_serial done");
   endtask

   task automatic test_rw(input logic m);
      logic [7:0] a;
      logic [7:0] d;
      int         r0;
      int         w0;
      u_ouhbp_host_model.set_mode(m);
      r0 = rd_cnt;
      w0 = wr_cnt;
      for (int c = 0; c < 8; c++)
      begin
         a = m ? {1'b0, 3'(c), 4'(c * 5)} : {1'b0, 3'(7 - c), 4'(15 - c * 3)};
         u_ouhbp_host_model.access(1'b1, 1'b1, a, ~a, d);
         check(last_wr.wdata, ~a, "write data");
         check({last_wr.global_sel, last_wr.chan, last_wr.index}, a, "write address");
         u_ouhbp_host_model.access(1'b0, 1'b1, a, 8'h00, d);
         check(d, a ^ 8'h5a, "read data");
         check(8'(oe_n), 8'h01, "bus released");
      end
      check(8'(rd_cnt - r0), 8'h08, "read count");
      check(8'(wr_cnt - w0), 8'h08, "write count");
      $display("test_rw mode %0d done", m);
   endtask

   task automatic test_deselect();
      logic [7:0] d;
      int         n;
      n = rd_cnt + wr_cnt + oe_cnt;
      u_ouhbp_host_model.access(1'b1, 1'b0, 8'h12, 8'h34, d);
      u_ouhbp_host_model.access(1'b0, 1'b0, 8'h12, 8'h00, d);
      check(8'(rd_cnt + wr_cnt + oe_cnt - n), 8'h00, "deselected access seen");
      $display("test_deselect done");
   endtask

   task automatic test_global();
      logic [7:0] pats [4] = '{8'h00, 8'h01, 8'h80, 8'ha5};
      logic [7:0] d;
      int         r0;
      foreach (pats[i])
      begin
         @(posedge mclk_i);
         chan_irq <= pats[i];
         repeat (8) @(posedge mclk_i);
         check(8'(int_oe_n), 8'(pats[i] == 8'h00), "interrupt drive");
         check(8'(int_n), 8'h00, "open drain level");
         check(8'(int_low), 8'(pats[i] != 8'h00), "interrupt line");
         r0 = rd_cnt;
         u_ouhbp_host_model.access(1'b0, 1'b1, 8'h80, 8'h00, d);
         check(d, pats[i], "interrupt source");
         check(8'(rd_cnt - r0), 8'h00, "source answered locally");
      end
      u_ouhbp_host_model.access(1'b1, 1'b1, 8'hd5, 8'h66, d);
      check({last_wr.global_sel, last_wr.chan, last_wr.index}, 8'hd5, "global write");
      u_ouhbp_host_model.access(1'b0, 1'b1, 8'hd5, 8'h00, d);
      check(d, 8'hd5 ^ 8'h5a, "global read");
      check(8'(last_rd.global_sel), 8'h01, "global select");
      $display("test_global done");
   endtask

   initial
   begin
      repeat (4) @(posedge mclk_i);
      check(8'({oe_n, int_oe_n, reg_rd, reg_wr, rx_core, ser_out}), 8'h33, "reset values");
      rst_i <= 1'b0;
      test_serial();
      test_rw(1'b1);
      test_deselect();
      test_global();
      test_rw(1'b0);
      finish_test();
   end
endmodule // tb
